// *** rtl/tfp_params.svh ***
// offsets, field positions, reset values and counts for the transmit pulse placer
`ifndef TFP_PARAMS_SVH
`define TFP_PARAMS_SVH
`define TFP_CFG_INDEX 8'h0e
`define TFP_STAT_INDEX 8'h0f
`define TFP_ADDR_W 10
`define TFP_OUT_POS_MSB 15
`define TFP_OUT_POS_LSB 8
`define TFP_IN_POS_MSB 7
`define TFP_IN_POS_LSB 0
`define TFP_OUT_POS_RST 8'h30
`define TFP_IN_POS_RST 8'h30
`define TFP_STAT_ERR_LSB 0
`define TFP_STAT_ACT_LSB 8
`define TFP_LANES 6
`define TFP_BPC_DIFF 9'h002
`define TFP_BPC_WIDE 9'h004
`define TFP_BPC_CHAN 9'h001
`define TFP_CNT_MAX 9'h1ff
`endif

// *** rtl/tfp_pkg.sv ***
// types shared by the transmit pulse placer
package tfp_pkg;
	// lane order inside the placer: diff bus, wide bus, then four channel buses
	typedef enum logic [2:0] {
		TFP_LANE_DIFF,
		TFP_LANE_WIDE,
		TFP_LANE_CH0,
		TFP_LANE_CH1,
		TFP_LANE_CH2,
		TFP_LANE_CH3
	} tfp_lane_t;
	// byte index within the first row of a frame, with headroom for wide lanes
	typedef logic [8:0] tfp_cnt_t;
	typedef logic [7:0] tfp_pos_t;
endpackage

// *** rtl/tfp_pulse_pos.sv ***
// transmit frame pulse placer with avalon-mm register slave
// Function
// - the pulse output is high in exactly the cycle the data bus carries the selected byte.
// - the 8-bit out position is a byte index in row one, 0 being the first A1 byte.
// - for OC-48 framing 47 is the last A1, 48 the first A2 and 144 the first SPE byte.
// - one out position setting serves the 16-bit, 32-bit and four 8-bit bus variants.
// - the out position lives in config bits 15:8, read/write, resetting to 30h.
// - a raised pulse input must coincide with the byte chosen by the in position in bits 7:0.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "tfp_params.svh"

module tfp_pulse_pos
	import tfp_pkg::*;
#(
	parameter int ADDR_W = `TFP_ADDR_W
) (
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave, byte addressed
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// upstream transmit data, same clock; sof marks the first A1 byte in the top lane
	input wire logic [15:0] diff_data_in,
	input wire logic diff_sof,
	input wire logic [31:0] wide_data_in,
	input wire logic wide_sof,
	input wire logic [3:0][7:0] chan_data_in,
	input wire logic [3:0] chan_sof,
	// line-side parallel buses and pulse outputs
	output logic [15:0] tx_parallel_bus_diff,
	output logic tx_pulse_out_diff,
	output logic [31:0] tx_parallel_bus_wide,
	output logic tx_pulse_out_wide,
	output logic [3:0][7:0] tx_parallel_bus_channel,
	output logic [3:0] tx_pulse_out_channel,
	// pulse inputs from the line side, asynchronous pins
	input wire logic tx_pulse_in_diff,
	input wire logic tx_pulse_in,
	input wire logic [3:0] tx_pulse_in_channel
);
	localparam int LANES = `TFP_LANES;
	localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'({`TFP_CFG_INDEX, 2'b00});
	localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'({`TFP_STAT_INDEX, 2'b00});

	// the byte-addressed status word at 3Ch fits in six address bits, yet ten are demanded here
	if (ADDR_W < 10) begin : g_addr_check
		$error("ADDR_W too narrow for the register map");
	end

	// bytes carried per cycle on each lane
	function automatic tfp_cnt_t lane_bpc(input int lane);
		if (lane == int'(TFP_LANE_DIFF)) begin
			return `TFP_BPC_DIFF;
		end else if (lane == int'(TFP_LANE_WIDE)) begin
			return `TFP_BPC_WIDE;
		end
		return `TFP_BPC_CHAN;
	endfunction

	// true when the beat starting at byte index cnt holds byte index pos
	function automatic logic beat_hit(input tfp_cnt_t cnt, input tfp_cnt_t bpc,
		input tfp_pos_t pos);
		logic [9:0] p;
		// one spare bit so a saturated index cannot wrap into a false hit
		p = {2'b00, pos};
		return (p >= {1'b0, cnt}) && (p < ({1'b0, cnt} + {1'b0, bpc}));
	endfunction

	// saturating advance, so the pulse cannot repeat later in a long frame
	function automatic tfp_cnt_t cnt_step(input tfp_cnt_t cnt, input tfp_cnt_t bpc);
		logic [9:0] s;
		s = {1'b0, cnt} + {1'b0, bpc};
		return (s > 10'({1'b0, `TFP_CNT_MAX})) ? `TFP_CNT_MAX : s[8:0];
	endfunction

	// ---------------- register slave ----------------
	logic [15:0] cfg_q, cfg_d;
	logic [LANES-1:0] err_q, err_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [LANES-1:0] active_q;
	tfp_pos_t out_pos;
	tfp_pos_t in_pos;
	logic [LANES-1:0] err_set;
	logic req;
	logic wr_go;

	assign out_pos = cfg_q[`TFP_OUT_POS_MSB:`TFP_OUT_POS_LSB];
	assign in_pos = cfg_q[`TFP_IN_POS_MSB:`TFP_IN_POS_LSB];
	assign req = avs_read | avs_write;
	// one wait state: every access completes on its second cycle
	assign avs_waitrequest = req & ~ack_q;
	assign wr_go = avs_write & ack_q;
	assign avs_readdata = rdata_q;

	// register next values; hardware set beats a software clear
	always_comb begin
		cfg_d = cfg_q;
		err_d = err_q;
		rdata_d = rdata_q;
		ack_d = req & ~ack_q;
		if (wr_go && avs_address == CFG_ADDR) begin
			if (avs_byteenable[1]) begin
				cfg_d[15:8] = avs_writedata[15:8];
			end
			if (avs_byteenable[0]) begin
				cfg_d[7:0] = avs_writedata[7:0];
			end
		end
		if (wr_go && avs_address == STAT_ADDR && avs_byteenable[0]) begin
			err_d = err_q & ~avs_writedata[LANES-1:0];
		end
		err_d = err_d | err_set;
		if (avs_read && !ack_q) begin
			if (avs_address == CFG_ADDR) begin
				rdata_d = {16'h0000, cfg_q};
			end else if (avs_address == STAT_ADDR) begin
				rdata_d = 32'h0;
				rdata_d[`TFP_STAT_ERR_LSB +: LANES] = err_q;
				rdata_d[`TFP_STAT_ACT_LSB +: LANES] = active_q;
			end else begin
				rdata_d = 32'h0; // unmapped reads as zero
			end
		end
	end

	// register state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= {`TFP_OUT_POS_RST, `TFP_IN_POS_RST};
			err_q <= '0;
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			err_q <= err_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ---------------- pulse placement ----------------
	logic [LANES-1:0] sof;
	logic [LANES-1:0] pin_in;
	tfp_cnt_t cnt_q [LANES];
	tfp_cnt_t cnt_d [LANES];
	tfp_cnt_t hist1_q [LANES];
	tfp_cnt_t hist2_q [LANES];
	logic [LANES-1:0] active_d;
	logic [LANES-1:0] pulse_q, pulse_d;
	logic [LANES-1:0] sync1_q, sync2_q;
	logic [LANES-1:0] hact1_q, hact2_q;
	logic [15:0] diff_q;
	logic [31:0] wide_q;
	logic [3:0][7:0] chan_q;

	assign sof = {chan_sof, wide_sof, diff_sof};
	assign pin_in = {tx_pulse_in_channel, tx_pulse_in, tx_pulse_in_diff};

	// byte index of each lane's next beat, and the pulse that travels with it
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			active_d[i] = active_q[i] | sof[i];
			if (sof[i]) begin
				cnt_d[i] = '0;
			end else begin
				cnt_d[i] = cnt_step(cnt_q[i], lane_bpc(i));
			end
			// one hit per frame since the index only climbs
			pulse_d[i] = active_d[i] & beat_hit(cnt_d[i], lane_bpc(i), out_pos);
			// a synchronised pin pulse is held against the index shown two beats back
			err_set[i] = sync2_q[i] & hact2_q[i]
				& ~beat_hit(hist2_q[i], lane_bpc(i), in_pos);
		end
	end

	// data, index and pulse registered together so they leave in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < LANES; i++) begin
				cnt_q[i] <= `TFP_CNT_MAX;
				hist1_q[i] <= `TFP_CNT_MAX;
				hist2_q[i] <= `TFP_CNT_MAX;
			end
			active_q <= '0;
			pulse_q <= '0;
			sync1_q <= '0;
			sync2_q <= '0;
			hact1_q <= '0;
			hact2_q <= '0;
			diff_q <= 16'h0;
			wide_q <= 32'h0;
			chan_q <= '0;
		end else begin
			for (int i = 0; i < LANES; i++) begin
				cnt_q[i] <= cnt_d[i];
				hist1_q[i] <= cnt_q[i];
				hist2_q[i] <= hist1_q[i];
			end
			active_q <= active_d;
			pulse_q <= pulse_d;
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			hact1_q <= active_q;
			hact2_q <= hact1_q;
			diff_q <= diff_data_in;
			wide_q <= wide_data_in;
			chan_q <= chan_data_in;
		end
	end

	// outputs straight from flops
	assign tx_parallel_bus_diff = diff_q;
	assign tx_parallel_bus_wide = wide_q;
	assign tx_parallel_bus_channel = chan_q;
	assign tx_pulse_out_diff = pulse_q[TFP_LANE_DIFF];
	assign tx_pulse_out_wide = pulse_q[TFP_LANE_WIDE];
	assign tx_pulse_out_channel = pulse_q[5:2];
endmodule

// *** tb/tfp_line_model.sv ***
// line-side model that answers on the transmit pulse input pins
`timescale 1ns/1ps
module tfp_line_model (
	input wire logic clk,
	input wire logic late,
	input wire logic [5:0] pulse_out,
	output logic [5:0] pulse_in
);
	logic [5:0] last_q;
	// one beat of delay gives the misaligned answer when commanded
	always_ff @(posedge clk) last_q <= pulse_out;
	assign pulse_in = late ? last_q : pulse_out;
endmodule

// *** tb/tfp_pulse_pos_sva.sv ***
// assertion checker for the transmit pulse placer
`timescale 1ns/1ps
module tfp_pulse_pos_sva #(parameter int ADDR_W = 10) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [31:0] wide_data_in,
	input wire logic wide_sof,
	input wire logic [3:0][7:0] chan_data_in,
	input wire logic [3:0] chan_sof,
	input wire logic [31:0] tx_parallel_bus_wide,
	input wire logic tx_pulse_out_wide,
	input wire logic [3:0][7:0] tx_parallel_bus_channel,
	input wire logic [3:0] tx_pulse_out_channel
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic seen_q;
	// a wide frame start must come before any wide pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			seen_q <= 1'b0;
		else if (wide_sof)
			seen_q <= 1'b1;
	end
	property p_wide_copy; !$past(rst) |-> tx_parallel_bus_wide == $past(wide_data_in); endproperty
	a_wide_copy: assert property (p_wide_copy) else $error("wide bus not one beat behind");
	property p_chan_copy; !$past(rst) |-> tx_parallel_bus_channel == $past(chan_data_in); endproperty
	a_chan_copy: assert property (p_chan_copy) else $error("channel bus not one beat behind");
	property p_one; tx_pulse_out_wide |=> !tx_pulse_out_wide; endproperty
	a_one: assert property (p_one) else $error("wide pulse longer than a beat");
	property p_early; !seen_q |-> !tx_pulse_out_wide; endproperty
	a_early: assert property (p_early) else $error("wide pulse before frame start");
	property p_wide_place; wide_sof |-> ##[1:64] tx_pulse_out_wide; endproperty
	a_wide_place: assert property (p_wide_place) else $error("no wide pulse in row one");
	property p_chan_place; chan_sof[2] |-> ##[1:256] tx_pulse_out_channel[2]; endproperty
	a_chan_place: assert property (p_chan_place) else $error("no channel pulse in row one");
	property p_wait; $rose(avs_read | avs_write) |-> avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("first request cycle not stalled");
	property p_unmapped; avs_read && !avs_waitrequest && avs_address == 'h100 |-> avs_readdata == 0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	c_wide: cover property (tx_pulse_out_wide);
	c_chan: cover property (tx_pulse_out_channel[2]);
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind tfp_pulse_pos tfp_pulse_pos_sva #(.ADDR_W(ADDR_W)) u_tfp_pulse_pos_sva (
	.clk(clk),
	.rst(rst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.wide_data_in(wide_data_in),
	.wide_sof(wide_sof),
	.chan_data_in(chan_data_in),
	.chan_sof(chan_sof),
	.tx_parallel_bus_wide(tx_parallel_bus_wide),
	.tx_pulse_out_wide(tx_pulse_out_wide),
	.tx_parallel_bus_channel(tx_parallel_bus_channel),
	.tx_pulse_out_channel(tx_pulse_out_channel)
);

// *** tb/tfp_pulse_pos_tb.sv ***
// self-checking bench for the transmit pulse placer
`timescale 1ns/1ps
module tfp_pulse_pos_tb;
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, go = 0, late = 0;
	logic diff_sof = 0, wide_sof = 0, avs_waitrequest, tx_pulse_out_diff, tx_pulse_out_wide;
	logic [9:0] avs_address = 0;
	logic [3:0] avs_byteenable = 4'hf, chan_sof = 0, tx_pulse_out_channel;
	logic [31:0] avs_writedata = 0, avs_readdata, q, wide_data_in = 0, tx_parallel_bus_wide;
	logic [15:0] diff_data_in = 0, tx_parallel_bus_diff;
	logic [3:0][7:0] chan_data_in = 0, tx_parallel_bus_channel;
	logic [7:0] pos = 0;
	logic [7:0] got [6];
	logic [15:0] rows [6] = '{16'h0000, 16'h0101, 16'h2f2f, 16'h3030, 16'h9090, 16'hffff};
	wire logic tx_pulse_in_diff, tx_pulse_in;
	wire logic [3:0] tx_pulse_in_channel;
	wire logic [5:0] pins;
	wire logic [5:0] pout = {tx_pulse_out_channel, tx_pulse_out_wide, tx_pulse_out_diff};
	int k = 0, j, error_cnt = 0, n_tests = 0, cnt [6];
	assign {tx_pulse_in_channel, tx_pulse_in, tx_pulse_in_diff} = pins;
	tfp_pulse_pos #(.ADDR_W(10)) u_tfp_pulse_pos (.*);
	tfp_line_model u_tfp_line_model (.clk(clk), .late(late), .pulse_out(pout), .pulse_in(pins));
	always #50 clk = ~clk;
	// frame source: every byte carries its own index in row one
	always @(posedge clk) begin
		j = go ? 0 : k;
		k <= j + 1;
		{diff_sof, wide_sof, chan_sof} <= {6{go}};
		diff_data_in <= {8'(2 * j), 8'(2 * j + 1)};
		wide_data_in <= {8'(4 * j), 8'(4 * j + 1), 8'(4 * j + 2), 8'(4 * j + 3)};
		chan_data_in <= {4{8'(j)}};
	end
	// pulse monitor, sampled mid-cycle when outputs have settled
	always @(negedge clk) begin
		for (int i = 0; i < 6; i++) if (pout[i]) begin
			cnt[i]++;
			got[i] = i == 0 ? 8'(tx_parallel_bus_diff >> 8 * (1 - pos % 2)) :
				i == 1 ? 8'(tx_parallel_bus_wide >> 8 * (3 - pos % 4)) : tx_parallel_bus_channel[i-2];
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// avalon request held until waitrequest is seen low, limited to 20 cycles
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			summarize();
		end
		// read data is taken at the very edge that sees waitrequest low
		q = avs_readdata;
		{avs_read, avs_write} <= 2'b00;
	endtask
	task automatic frame();
		foreach (cnt[i]) cnt[i] = 0;
		@(posedge clk);
		go <= 1;
		@(posedge clk);
		go <= 0;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		bus(0, 10'h038, 0);
		chk("cfg_reset", 32'h3030, q);
		bus(1, 10'h100, 32'hffff);
		bus(0, 10'h100, 0);
		chk("unmapped", 0, q);
		foreach (rows[r]) begin
			bus(1, 10'h038, rows[r]);
			bus(0, 10'h038, 0);
			chk("cfg", rows[r], q);
			pos = rows[r][15:8];
			frame();
			repeat (270) @(posedge clk);
			for (int i = 0; i < 6; i++) begin
				chk("pulse_count", 1, cnt[i]);
				chk("pulse_byte", pos, got[i]);
			end
		end
		bus(0, 10'h03c, 0);
		chk("aligned_err", 0, q[5:0]);
		chk("lanes_active", 6'h3f, q[13:8]);
		late <= 1;
		frame();
		repeat (270) @(posedge clk);
		bus(0, 10'h03c, 0);
		chk("late_err", 6'h3f, q[5:0]);
		bus(1, 10'h03c, 32'h3f);
		bus(0, 10'h03c, 0);
		chk("err_clear", 0, q[5:0]);
		avs_byteenable <= 4'h1;
		bus(1, 10'h038, 32'h1234);
		avs_byteenable <= 4'hf;
		bus(0, 10'h038, 0);
		chk("cfg_lane", 32'hff34, q);
		frame();
		repeat (5) @(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		repeat (270) @(posedge clk);
		foreach (cnt[i]) chk("quiet", 0, cnt[i]);
		bus(0, 10'h038, 0);
		chk("cfg_rereset", 32'h3030, q);
		bus(0, 10'h03c, 0);
		chk("active_rereset", 0, q[13:8]);
		summarize();
	end
endmodule
